// >>> rtl/spi_cmd_pkg.sv
// constants shared by the position command port
package spi_cmd_pkg;

    // command codes, first byte of every frame
    localparam logic [7:0] OP_ACTIVATE = 8'hB0;
    localparam logic [7:0] OP_POS_READ = 8'hA6;
    localparam logic [7:0] OP_POS_STATUS = 8'hF5;
    localparam logic [7:0] OP_REG_READ = 8'h8A;
    localparam logic [7:0] OP_REG_WRITE = 8'hCF;
    localparam logic [7:0] OP_REG_STATUS = 8'hAD;

    // register addresses, low five bits of the address byte
    localparam logic [4:0] ADR_OUTPUT_FORMAT = 5'h07;
    localparam logic [4:0] ADR_SHIFT_LENGTH = 5'h08;
    localparam logic [4:0] ADR_FLEX_CTRL = 5'h0B;
    localparam logic [4:0] ADR_RESOLUTION = 5'h0E;
    localparam logic [4:0] ADR_SUB_LO = 5'h0F;
    localparam logic [4:0] ADR_SUB_MID = 5'h10;
    localparam logic [4:0] ADR_SUB_HI = 5'h11;
    localparam logic [4:0] ADR_LAST_RW = 5'h11;
    localparam logic [4:0] ADR_STATUS = 5'h12;
    localparam int NUM_CFG = 18;

    // field positions
    localparam int BINARY_FORMAT_BIT = 6;
    localparam int SHIFT_LENGTH_LSB = 0;
    localparam int NATIVE_SEL_BIT = 2;
    localparam int RES_IPO_LSB = 5;
    localparam int ACT_REG_BIT = 1;
    localparam int ACT_POS_BIT = 0;

    // spi status byte
    localparam int ST_ERROR = 7;
    localparam int ST_DISMISS = 3;
    localparam int ST_FAIL = 2;
    localparam int ST_BUSY = 1;
    localparam int ST_VALID = 0;

    // values after reset
    localparam logic REG_EN_RESET = 1'b1;
    localparam logic POS_EN_RESET = 1'b0;
    localparam logic [NUM_CFG-1:0][7:0] CFG_RESET = {
        8'hA0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h8E, 8'h00, 8'h00,
        8'h18, 8'h09, 8'h60, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hA0, 8'hA0};

    // position frame
    localparam int POS_BITS = 18;
    localparam logic [4:0] POS_BITS_W = 5'h12;
    localparam logic [2:0] LEN_SHORT_MIN = 3'h2;
    localparam logic [7:0][4:0] LEN_USED_BITS = {
        5'h0C, 5'h0D, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};
    localparam logic [2:0] BYTE_CNT_MAX = 3'h4;

    // frame phase
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_OPCODE = 3'b010,
        PH_BODY = 3'b100
    } phase_e;

endpackage : spi_cmd_pkg

// >>> rtl/spi_slave_position_cmd_port.sv
// spi command port with register file, position frame and write fifo
// Function
// - works in spi modes 0 and 3; mosi is taken on rising sclk edges
// - miso is high impedance while chip select is low
// - chip select rising starts a frame; mosi is echoed on miso
// - all traffic is whole bytes, most significant bit first
// - chip select falling ends the frame and releases miso
// - first byte is the command: activate b0, position read a6, status f5
// - register read 8a, register write cf, register status ad
// - activate loads both enables and clears fail, valid, busy, dismiss in one step
// - byte after activate: bit 1 register channel, bit 0 position channel
// - after power-on register channel on, position channel off
// - register commands refused and error set while register channel off
// - position read refused and error set while position channel off
// - refused commands are still echoed from mosi to miso
// - position captured on first rising sclk of frame, then up to three bytes
// - bit 6 of address 07 picks gray (0) or binary (1) output
// - invalid position sets error and sends all position bytes as zero
// - length field 08 bits 2:0 sets frame length and used bit count
// - length two or more sends two position bytes, otherwise three
// - position msb first, left-justified, lower frame bits zero
// - programmable resolution mode takes valid bits from sub-resolution value
// - native mode takes valid bits from interpolator field 0e bits 6:5
// - status byte: error 7, dismiss 3, fail 2, busy 1, valid 0
// - register read streams from incrementing addresses while selected
// - status refreshed on each register access; error follows last command

module write_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic push;
    logic pop;

    // count is one bit wider than the pointers so a full queue is told from an empty one
    assign in_ready = (q.cnt != (PW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = in_data;
            d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + PW'(1);
        end
        if (pop)
        begin
            d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + PW'(1);
        end
        d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule : write_fifo

module spi_slave_position_cmd_port #(
    parameter logic [3:0] CHIP_VERSION = 4'h5, // arbitrary value
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // spi pins
    input wire logic spi_cs,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    // position source, same clock
    input wire logic [17:0] position_value,
    input wire logic position_ok,
    // configuration seen by the rest of the device
    output logic register_channel_enable,
    output logic position_channel_enable,
    output logic binary_format_select,
    output logic [2:0] shift_length_sel,
    output logic config_parity_error
);
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sclk_s;
        logic [1:0] mosi_s;
        logic sclk_prev;
        logic cs_prev;
        spi_cmd_pkg::phase_e ph;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] rx_sh;
        logic [7:0] opcode;
        logic cmd_ok;
        logic [7:0] tx_sh;
        logic tx_on;
        logic miso;
        logic oe_n;
        logic [4:0] addr;
        logic addr_stop;
        logic first_rise;
        logic pos_bad;
        logic [23:0] pos_frame;
        logic reg_en;
        logic pos_en;
        logic err;
        logic dismiss;
        logic fail;
        logic busy;
        logic valid;
        logic [spi_cmd_pkg::NUM_CFG-1:0][7:0] cfg;
    } port_s;

    port_s q;
    port_s d;
    logic [1:0] rst_sync;
    logic rst_int_n;

    logic push_valid;
    logic push_ready;
    logic [12:0] push_data;
    logic drain_valid;
    logic drain_ready;
    logic [12:0] drain_data;

    logic [17:0] sub_res;
    logic [4:0] valid_bits;
    logic [4:0] used_bits;
    logic [17:0] pos_code;
    logic [23:0] pos_mask;
    logic [7:0] status_byte;
    logic [7:0] status_reg;
    logic [7:0] read_byte;
    logic parity_any;

    // reset release through two flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync[1];

    // register writes queue here; draining waits while a read stream runs
    write_fifo #(
        .WIDTH(13),
        .DEPTH(FIFO_DEPTH)
    ) u_write_fifo (
        .clk(mclk),
        .rst_n(rst_int_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    assign drain_ready = ~(q.ph == spi_cmd_pkg::PH_BODY && q.opcode == spi_cmd_pkg::OP_REG_READ);

    // frame layout from configuration
    always_comb
    begin
        sub_res = {q.cfg[spi_cmd_pkg::ADR_SUB_HI][3:0], q.cfg[spi_cmd_pkg::ADR_SUB_MID][6:0],
                   q.cfg[spi_cmd_pkg::ADR_SUB_LO][6:0]};
        valid_bits = 5'h00;
        if (q.cfg[spi_cmd_pkg::ADR_FLEX_CTRL][spi_cmd_pkg::NATIVE_SEL_BIT])
        begin
            valid_bits = spi_cmd_pkg::POS_BITS_W -
                {3'h0, q.cfg[spi_cmd_pkg::ADR_RESOLUTION][spi_cmd_pkg::RES_IPO_LSB +: 2]};
        end
        else
        begin
            for (int i = 0; i < spi_cmd_pkg::POS_BITS; i++)
            begin
                if (sub_res[i])
                begin
                    valid_bits = 5'(i + 1);
                end
            end
        end
        used_bits = spi_cmd_pkg::LEN_USED_BITS[q.cfg[spi_cmd_pkg::ADR_SHIFT_LENGTH][2:0]];
        if (valid_bits < used_bits)
        begin
            used_bits = valid_bits;
        end
        pos_mask = ~(24'hFFFFFF >> used_bits);
        if (q.cfg[spi_cmd_pkg::ADR_OUTPUT_FORMAT][spi_cmd_pkg::BINARY_FORMAT_BIT])
        begin
            pos_code = position_value;
        end
        else
        begin
            pos_code = position_value ^ (position_value >> 1);
        end
        parity_any = 1'b0;
        for (int i = 0; i < spi_cmd_pkg::NUM_CFG; i++)
        begin
            parity_any = parity_any | (^q.cfg[i]);
        end
    end

    // status byte and register read data
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[spi_cmd_pkg::ST_ERROR] = q.err;
        status_byte[spi_cmd_pkg::ST_DISMISS] = q.dismiss;
        status_byte[spi_cmd_pkg::ST_FAIL] = q.fail;
        status_byte[spi_cmd_pkg::ST_BUSY] = q.busy;
        status_byte[spi_cmd_pkg::ST_VALID] = q.valid;
        status_reg = {CHIP_VERSION, 1'b0, parity_any, 1'b0, position_ok};
        if (q.addr == spi_cmd_pkg::ADR_STATUS)
        begin
            read_byte = status_reg;
        end
        else if (q.addr <= spi_cmd_pkg::ADR_LAST_RW)
        begin
            read_byte = q.cfg[q.addr];
        end
        else
        begin
            read_byte = 8'h00;
        end
    end

    // write requests leave on the last rising edge of a data byte
    always_comb
    begin
        push_data = {q.addr, q.rx_sh[6:0], q.mosi_s[1]};
        push_valid = (q.ph == spi_cmd_pkg::PH_BODY) && q.cmd_ok && q.cs_s[1] && q.sclk_s[1] && !q.sclk_prev &&
                     (q.bit_cnt == 3'h7) && (q.opcode == spi_cmd_pkg::OP_REG_WRITE) &&
                     (q.byte_cnt >= 3'h2) && !q.addr_stop && (q.addr <= spi_cmd_pkg::ADR_LAST_RW);
    end

    always_comb
    begin
        logic cs;
        logic sck;
        logic mosi;
        logic rise;
        logic fall;
        logic [7:0] rx_byte;
        logic [7:0] tx_byte;
        logic tx_load;
        cs = q.cs_s[1];
        sck = q.sclk_s[1];
        mosi = q.mosi_s[1];
        rise = cs & sck & ~q.sclk_prev;
        fall = cs & ~sck & q.sclk_prev;
        rx_byte = {q.rx_sh[6:0], mosi};
        tx_byte = 8'h00;
        tx_load = 1'b0;
        d = q;
        d.cs_s = {q.cs_s[0], spi_cs};
        d.sclk_s = {q.sclk_s[0], spi_sclk};
        d.mosi_s = {q.mosi_s[0], spi_mosi};
        d.sclk_prev = sck;
        d.cs_prev = cs;

        if (drain_valid && drain_ready)
        begin
            d.cfg[drain_data[12:8]] = drain_data[7:0];
        end

        if (!cs)
        begin
            d.ph = spi_cmd_pkg::PH_IDLE;
            d.tx_on = 1'b0;
            d.cmd_ok = 1'b0;
        end
        else if (!q.cs_prev)
        begin
            d.ph = spi_cmd_pkg::PH_OPCODE;
            d.bit_cnt = 3'h0;
            d.byte_cnt = 3'h0;
            d.first_rise = 1'b1;
            d.tx_on = 1'b0;
        end
        else if (rise)
        begin
            d.rx_sh = rx_byte;
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.first_rise)
            begin
                d.first_rise = 1'b0;
                d.pos_bad = ~position_ok;
                d.pos_frame = position_ok ? ({pos_code, 6'h00} & pos_mask) : 24'h000000;
            end
            if (q.bit_cnt == 3'h7)
            begin
                if (q.byte_cnt != spi_cmd_pkg::BYTE_CNT_MAX)
                begin
                    d.byte_cnt = q.byte_cnt + 3'h1;
                end
                if (q.ph == spi_cmd_pkg::PH_OPCODE)
                begin
                    d.opcode = rx_byte;
                    d.ph = spi_cmd_pkg::PH_BODY;
                    case (rx_byte)
                        spi_cmd_pkg::OP_ACTIVATE,
                        spi_cmd_pkg::OP_POS_STATUS:
                        begin
                            d.cmd_ok = 1'b1;
                            d.err = 1'b0;
                        end
                        spi_cmd_pkg::OP_POS_READ:
                        begin
                            d.cmd_ok = q.pos_en;
                            d.err = ~q.pos_en | q.pos_bad | d.pos_bad;
                        end
                        spi_cmd_pkg::OP_REG_READ,
                        spi_cmd_pkg::OP_REG_WRITE,
                        spi_cmd_pkg::OP_REG_STATUS:
                        begin
                            d.cmd_ok = q.reg_en;
                            d.err = ~q.reg_en;
                        end
                        default:
                        begin
                            d.cmd_ok = 1'b0;
                            d.err = 1'b1;
                        end
                    endcase
                end
                else if (q.ph == spi_cmd_pkg::PH_BODY && q.cmd_ok)
                begin
                    case (q.opcode)
                        spi_cmd_pkg::OP_ACTIVATE:
                        begin
                            // clear and reload in one step, so a cut frame changes nothing
                            if (q.byte_cnt == 3'h1)
                            begin
                                d.reg_en = rx_byte[spi_cmd_pkg::ACT_REG_BIT];
                                d.pos_en = rx_byte[spi_cmd_pkg::ACT_POS_BIT];
                                d.fail = 1'b0;
                                d.valid = 1'b0;
                                d.busy = 1'b0;
                                d.dismiss = 1'b0;
                            end
                        end
                        spi_cmd_pkg::OP_REG_READ,
                        spi_cmd_pkg::OP_REG_WRITE:
                        begin
                            if (q.byte_cnt == 3'h1)
                            begin
                                d.addr = rx_byte[4:0];
                                d.addr_stop = 1'b0;
                            end
                            else
                            begin
                                d.valid = position_ok;
                                d.busy = drain_valid;
                                if (q.opcode == spi_cmd_pkg::OP_REG_WRITE &&
                                    (q.addr > spi_cmd_pkg::ADR_LAST_RW || q.addr_stop))
                                begin
                                    d.dismiss = 1'b1;
                                    d.fail = 1'b1;
                                    d.addr_stop = 1'b1;
                                end
                                else if (push_valid && !push_ready)
                                begin
                                    // queue full: this byte is lost, master sees fail
                                    d.fail = 1'b1;
                                    d.addr_stop = 1'b1;
                                end
                                else if (!d.addr_stop)
                                begin
                                    d.addr = q.addr + 5'h01;
                                end
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
        end
        else if (fall)
        begin
            if (q.bit_cnt == 3'h0)
            begin
                if (q.ph == spi_cmd_pkg::PH_BODY && q.cmd_ok)
                begin
                    case (q.opcode)
                        spi_cmd_pkg::OP_POS_READ:
                        begin
                            case (q.byte_cnt)
                                3'h1:
                                begin
                                    tx_byte = q.pos_frame[23:16];
                                    tx_load = 1'b1;
                                end
                                3'h2:
                                begin
                                    tx_byte = q.pos_frame[15:8];
                                    tx_load = 1'b1;
                                end
                                3'h3:
                                begin
                                    tx_byte = q.pos_frame[7:0];
                                    tx_load = (q.cfg[spi_cmd_pkg::ADR_SHIFT_LENGTH][2:0] <
                                               spi_cmd_pkg::LEN_SHORT_MIN);
                                end
                                default:
                                begin
                                    tx_load = 1'b0;
                                end
                            endcase
                        end
                        spi_cmd_pkg::OP_REG_READ:
                        begin
                            if (q.byte_cnt >= 3'h2)
                            begin
                                tx_load = 1'b1;
                                if (q.addr > spi_cmd_pkg::ADR_STATUS || q.addr_stop)
                                begin
                                    d.dismiss = 1'b1;
                                    d.fail = 1'b1;
                                    d.addr_stop = 1'b1;
                                end
                                else
                                begin
                                    tx_byte = read_byte;
                                end
                            end
                        end
                        spi_cmd_pkg::OP_REG_STATUS:
                        begin
                            tx_byte = status_byte;
                            tx_load = (q.byte_cnt == 3'h1);
                        end
                        default:
                        begin
                            tx_load = 1'b0;
                        end
                    endcase
                end
                d.tx_on = tx_load;
                d.miso = tx_byte[7];
                d.tx_sh = {tx_byte[6:0], 1'b0};
            end
            else if (q.tx_on)
            begin
                d.miso = q.tx_sh[7];
                d.tx_sh = {q.tx_sh[6:0], 1'b0};
            end
        end

        if (!d.tx_on)
        begin
            d.miso = mosi;
        end
        d.oe_n = ~cs;
    end

    always_ff @(posedge mclk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            q <= '0;
            q.ph <= spi_cmd_pkg::PH_IDLE;
            q.oe_n <= 1'b1;
            q.reg_en <= spi_cmd_pkg::REG_EN_RESET;
            q.pos_en <= spi_cmd_pkg::POS_EN_RESET;
            q.cfg <= spi_cmd_pkg::CFG_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign spi_miso = q.miso;
    assign spi_miso_oe_n = q.oe_n;
    assign register_channel_enable = q.reg_en;
    assign position_channel_enable = q.pos_en;
    assign binary_format_select = q.cfg[spi_cmd_pkg::ADR_OUTPUT_FORMAT][spi_cmd_pkg::BINARY_FORMAT_BIT];
    assign shift_length_sel = q.cfg[spi_cmd_pkg::ADR_SHIFT_LENGTH][2:0];
    assign config_parity_error = parity_any;

endmodule : spi_slave_position_cmd_port

// >>> tb/spi_master_model.sv
// spi master model driving the command port pins
module spi_master_model (
    // clock and mode
    input wire logic mclk,
    input wire logic cpol,
    // spi pins
    output logic spi_cs,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    // received bytes
    output logic [7:0] rx_data,
    output logic rx_stb
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {spi_cs, spi_sclk, spi_mosi, rx_data, rx_stb} = '0;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic start();
        tick(1);
        spi_sclk = cpol;
        tick(4);
        spi_cs = 1'b1;
        tick(4);
    endtask : start
    // data set at the fall, taken at the rise; four mclk per half period
    task automatic xbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            spi_sclk = 1'b0;
            spi_mosi = b[i];
            tick(4);
            rx_data[i] = spi_miso;
            spi_sclk = 1'b1;
            tick(4);
        end
        rx_stb = 1'b1;
        tick(1);
        rx_stb = 1'b0;
    endtask : xbyte
    // released mosi flips so a stale level never passes for data
    task automatic stop();
        spi_sclk = cpol;
        tick(4);
        spi_cs = 1'b0;
        spi_mosi = ~spi_mosi;
        tick(6);
    endtask : stop
endmodule : spi_master_model

// >>> tb/spi_slave_position_cmd_port_chk.sv
// pin assertions for the command port
module spi_port_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // spi pins
    input wire logic spi_cs,
    input wire logic spi_sclk,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n,
    // configuration
    input wire logic register_channel_enable,
    input wire logic position_channel_enable,
    input wire logic binary_format_select,
    input wire logic [2:0] shift_length_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_miso_hiz_idle: assert property (!spi_cs [*4] |-> spi_miso_oe_n)
        else $error("miso driven while deselected");
    a_oe_on_select: assert property ($rose(spi_cs) |-> ##[2:4] !spi_miso_oe_n)
        else $error("miso not driven after select");
    a_oe_held_on: assert property (spi_cs [*5] |-> !spi_miso_oe_n)
        else $error("miso dropped inside frame");
    a_release_at_end: assert property ($fell(spi_cs) |-> ##[2:4] spi_miso_oe_n)
        else $error("miso not released");
    a_miso_on_fall: assert property (
        (spi_cs && spi_sclk && !spi_miso_oe_n && $past(!spi_miso_oe_n, 3)) [*5] |-> $stable(spi_miso))
        else $error("miso moved while sclk high");
    a_enables_idle: assert property (
        !spi_cs [*6] |=> $stable({register_channel_enable, position_channel_enable}))
        else $error("enables moved outside frame");
    a_enables_reset: assert property ($rose(rst_n) |-> register_channel_enable && !position_channel_enable)
        else $error("bad enables after reset");
    a_format_reset: assert property ($rose(rst_n) |-> !binary_format_select && shift_length_sel == 3'h0)
        else $error("bad format after reset");
endmodule : spi_port_chk
bind spi_slave_position_cmd_port spi_port_chk i_chk (.*);

// >>> tb/spi_slave_position_cmd_port_tb.sv
// self-checking bench for the spi position command port
module spi_slave_position_cmd_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, cpol, ok;
    logic [17:0] pos;
    logic [8:0] exq[$];
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    wire logic cs, sclk, mosi, miso, oe_n, reg_en, pos_en, bin, stb, perr;
    wire logic [2:0] len_sel;
    wire logic [7:0] rx;
    wire logic miso_w = oe_n ? 1'bz : miso;
    spi_slave_position_cmd_port i_dut (.mclk(mclk), .rst_n(rst_n), .spi_cs(cs), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(oe_n), .position_value(pos),
        .position_ok(ok), .register_channel_enable(reg_en), .position_channel_enable(pos_en),
        .binary_format_select(bin), .shift_length_sel(len_sel), .config_parity_error(perr));
    spi_master_model i_mst (.mclk(mclk), .cpol(cpol), .spi_cs(cs), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_miso(miso_w), .rx_data(rx), .rx_stb(stb));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // c low: byte has no fixed answer
    task automatic sb(input logic [7:0] t, input logic [7:0] e, input logic c = 1'b1);
        exq.push_back({c, e});
        i_mst.xbyte(t);
    endtask : sb
    task automatic act(input logic [7:0] v);
        i_mst.start();
        sb(8'hB0, 8'hB0);
        sb(v, 8'h00, 1'b0);
        i_mst.stop();
    endtask : act
    task automatic rd_pos(input logic gray, input int used, input int nb);
        logic [23:0] f;
        f = {gray ? pos ^ (pos >> 1) : pos, 6'h00} & ~(24'hFFFFFF >> used);
        i_mst.start();
        sb(8'hA6, 8'hA6);
        sb(8'h00, f[23:16]);
        sb(8'h00, f[15:8]);
        if (nb == 3)
            sb(8'h00, f[7:0]);
        i_mst.stop();
    endtask : rd_pos
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        logic [8:0] n;
        cyc <= cyc + 1;
        if (stb === 1'b1)
        begin
            n = exq.pop_front();
            if (n[8])
                chk("miso byte", n[7:0], rx);
        end
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        cpol = 1'b0;
        ok = 1'b1;
        pos = 18'($urandom(34870));
        repeat (4) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge mclk);
        chk("reg_en", 8'h01, 8'(reg_en));
        chk("pos_en", 8'h00, 8'(pos_en));
        i_mst.start();
        sb(8'h8A, 8'h8A);
        sb(8'h07, 8'h07);
        sb(8'h00, 8'h09);
        sb(8'h00, 8'h18);
        i_mst.stop();
        rd_pos(1'b0, 0, 1);
        act(8'h01);
        chk("reg_en", 8'h00, 8'(reg_en));
        chk("pos_en", 8'h01, 8'(pos_en));
        i_mst.start();
        sb(8'h8A, 8'h8A);
        sb(8'h07, 8'h07);
        sb(8'hC3, 8'hC3);
        i_mst.stop();
        rd_pos(1'b1, 18, 3);
        act(8'h03);
        i_mst.start();
        sb(8'hAD, 8'hAD);
        sb(8'h00, 8'h00);
        i_mst.stop();
        cpol = 1'b1;
        i_mst.start();
        sb(8'hCF, 8'hCF);
        sb(8'h07, 8'h07);
        sb(8'hC9, 8'hC9);
        sb(8'h1B, 8'h1B);
        sb(8'h01, 8'h01);
        i_mst.stop();
        for (int i = 0; i < 60 && len_sel !== 3'h3; i++) @(posedge mclk);
        chk("bin", 8'h01, 8'(bin));
        chk("len_sel", 8'h03, 8'(len_sel));
        chk("parity", 8'h01, 8'(perr));
        #1 pos = 18'($urandom);
        rd_pos(1'b0, 15, 2);
        ok = 1'b0;
        rd_pos(1'b0, 0, 2);
        end_of_test();
    end
endmodule : spi_slave_position_cmd_port_tb
